// ### rtl/memory_map_decoder.sv
// address-map decoder with apb mapping registers and registered decode result
`timescale 1ns/10ps
`default_nettype none
`include "memory_map_defs.svh"

module memory_map_decoder
#(
   parameter int ADDR_W = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mode_special,
   input wire logic mode_expanded,
   input wire logic mode_wide,
   input wire logic debug_rom_active,
   input wire logic acc_valid,
   input wire logic [15:0] acc_addr,
   input wire logic acc_16bit,
   output logic dec_valid,
   output memory_map_pkg::resource_t dec_resource,
   output logic dec_bus_wide,
   output logic [1:0] dec_stretch,
   output logic dec_addr0,
   output logic low_byte_strobe_n
);
   import memory_map_pkg::*;

   localparam logic [ADDR_W-1:0] ADR_RAM = ADDR_W'({`MM_IDX_RAM_POS, 2'b00});
   localparam logic [ADDR_W-1:0] ADR_REG = ADDR_W'({`MM_IDX_REG_POS, 2'b00});
   localparam logic [ADDR_W-1:0] ADR_EE = ADDR_W'({`MM_IDX_EE_POS, 2'b00});
   localparam logic [ADDR_W-1:0] ADR_MISC = ADDR_W'({`MM_IDX_MISC, 2'b00});

   logic [7:0] ram_pos_q;
   logic [7:0] reg_pos_q;
   logic [7:0] ee_pos_q;
   logic [7:0] misc_q;
   logic [3:0] written_q;
   logic init_q;
   logic [3:0] hit;
   logic mapped;
   logic setup;
   logic wr_fire;
   logic [3:0] wr_ok;
   logic [7:0] rd_byte;
   resource_t res_d;
   logic wide_d;
   logic [1:0] stretch_d;
   logic low_byte_strobe_n_d;

   // apb phases: one setup cycle, answered in the following access cycle
   always_comb
   begin
      setup = psel && !penable;
      hit[0] = paddr == ADR_RAM;
      hit[1] = paddr == ADR_REG;
      hit[2] = paddr == ADR_EE;
      hit[3] = paddr == ADR_MISC;
      mapped = |hit;
      wr_fire = psel && penable && pready && pwrite && pstrb[0];
   end

   // write-once gate per register; special modes never lock
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_lock
         assign wr_ok[g] = wr_fire && hit[g] && (mode_special || !written_q[g]);
      end
   endgenerate

   // lock flags; any landed write arms the lock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         written_q <= 4'h0;
      else
         written_q <= written_q | ({4{wr_fire}} & hit);
   end

   // ram position; low bits held at zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ram_pos_q <= `MM_RAM_POS_RST;
      else if (wr_ok[0])
         ram_pos_q <= {pwdata[`MM_BASE5_HI:`MM_BASE5_LO], 3'b000};
   end

   // register block position, following space rides along with it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reg_pos_q <= `MM_REG_POS_RST;
      else if (wr_ok[1])
         reg_pos_q <= {pwdata[`MM_BASE5_HI:`MM_BASE5_LO], 3'b000};
   end

   // eeprom position: base bits and enable
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ee_pos_q <= `MM_EE_POS_RST;
      else if (wr_ok[2])
      begin
         ee_pos_q <= '0;
         ee_pos_q[`MM_EE_BASE_HI:`MM_EE_BASE_LO] <= pwdata[`MM_EE_BASE_HI:`MM_EE_BASE_LO];
         ee_pos_q[`MM_EE_ENABLE] <= pwdata[`MM_EE_ENABLE];
      end
   end

   // mode strap seen once after reset release, never under the async reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         init_q <= 1'b0;
      else
         init_q <= 1'b1;
   end

   // misc control; flash enables follow the mode on the first clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         misc_q <= `MM_MISC_RST;
      else if (wr_ok[3])
         misc_q <= pwdata[7:0];
      else if (!init_q && !mode_expanded)
         misc_q[`MM_SMALL_FLASH_EN:`MM_LARGE_FLASH_EN] <= `MM_FLASH_EN_SC;
   end

   // read mux, all registers readable at any time
   always_comb
   begin
      rd_byte = 8'h00;
      case (1'b1)
         hit[0]: rd_byte = ram_pos_q;
         hit[1]: rd_byte = reg_pos_q;
         hit[2]: rd_byte = ee_pos_q;
         hit[3]: rd_byte = misc_q;
         default: rd_byte = 8'h00;
      endcase
   end

   // answer staged in setup so every bus output is a flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup && !mapped; // unmapped offsets answer with an error
         prdata <= (setup && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // priority decode of the presented access against the live map
   map_resolve u_resolve
   (
      .addr(acc_addr),
      .ram_pos(ram_pos_q),
      .reg_pos(reg_pos_q),
      .ee_pos(ee_pos_q),
      .misc(misc_q),
      .mode_expanded(mode_expanded),
      .mode_wide(mode_wide),
      .debug_rom_active(debug_rom_active),
      .resource(res_d),
      .bus_wide(wide_d),
      .stretch(stretch_d)
   );

   // strobe: high only for byte at even, or misaligned word into ram
   always_comb
   begin
      if (acc_16bit)
         low_byte_strobe_n_d = acc_addr[0] && res_d == res_ram;
      else
         low_byte_strobe_n_d = !acc_addr[0];
   end

   // result register; a map write lands one cycle before its first use
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dec_valid <= 1'b0;
         dec_resource <= res_none;
         dec_bus_wide <= 1'b1;
         dec_stretch <= 2'b00;
         dec_addr0 <= 1'b0;
         low_byte_strobe_n <= 1'b1;
      end
      else
      begin
         dec_valid <= acc_valid;
         dec_resource <= acc_valid ? res_d : res_none;
         dec_bus_wide <= acc_valid ? wide_d : 1'b1;
         dec_stretch <= acc_valid ? stretch_d : 2'b00;
         dec_addr0 <= acc_valid && acc_addr[0];
         low_byte_strobe_n <= acc_valid ? low_byte_strobe_n_d : 1'b1;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // checks
   a_ram_low_zero: assert property (ram_pos_q[2:0] == 3'b000 && reg_pos_q[2:0] == 3'b000)
      else $error("position register low bits not zero");

   a_lock_holds: assert property (wr_fire && hit[0] && !mode_special && written_q[0]
      |=> $stable(ram_pos_q))
      else $error("locked ram position changed in normal mode");

   a_special_write: assert property (wr_fire && hit[3] && mode_special
      |=> misc_q == $past(pwdata[7:0]))
      else $error("special mode misc write not stored");

   a_regs_over_ram: assert property (acc_valid && !debug_rom_active
      && acc_addr[15:11] == reg_pos_q[7:3] && acc_addr[10:9] == 2'b00
      |=> dec_resource == res_registers)
      else $error("register block did not win overlap");

   a_eeprom_gated: assert property (acc_valid && !ee_pos_q[`MM_EE_ENABLE]
      |=> dec_resource != res_eeprom)
      else $error("eeprom decoded while disabled");

   a_no_ext_sc: assert property (acc_valid && !mode_expanded
      |=> dec_resource != res_external && dec_resource != res_following
      && dec_stretch == 2'b00)
      else $error("off-chip decode in single chip mode");

   a_ext_claims: assert property (acc_valid && mode_expanded |=> dec_resource != res_none)
      else $error("expanded mode left an address unclaimed");

   a_follow_narrow: assert property (dec_valid && dec_resource == res_following
      && $past(misc_q[`MM_NARROW_FOLLOW]) |-> !dec_bus_wide)
      else $error("narrow following space decoded wide");

   a_ext_stretch: assert property (acc_valid && mode_expanded
      ##1 dec_resource == res_external |-> dec_stretch == $past(misc_q[3:2]))
      else $error("external stretch mismatch");

   a_ram_strobe: assert property (dec_valid && low_byte_strobe_n && dec_addr0
      |-> dec_resource == res_ram)
      else $error("strobe and a0 high outside ram");

   a_swap_large: assert property (acc_valid && misc_q[`MM_FLASH_SWAP]
      && misc_q[`MM_LARGE_FLASH_EN] && !acc_addr[15] && !debug_rom_active
      && acc_addr[15:11] != reg_pos_q[7:3] && acc_addr[15:11] != ram_pos_q[7:3]
      && !(ee_pos_q[0] && acc_addr[15:12] == ee_pos_q[7:4])
      |=> dec_resource == res_large_flash)
      else $error("swapped large flash not in low half");

   a_apb_answer: assert property (setup |=> pready ##1 !pready)
      else $error("apb answer not a single cycle after setup");

   c_ram_misaligned: cover property (dec_valid && dec_resource == res_ram
      && low_byte_strobe_n && dec_addr0);
   c_map_rewrite: cover property (wr_ok[1] ##2 dec_valid && dec_resource == res_registers);
   c_follow_stretch: cover property (dec_valid && dec_resource == res_following
      && dec_stretch == 2'b11);
   c_unmapped: cover property (pready && pslverr);
endmodule
`default_nettype wire

// ### rtl/memory_map_defs.svh
// constants for the address-map decoder: offsets, fields, reset values, windows
`ifndef MEMORY_MAP_DEFS_SVH
`define MEMORY_MAP_DEFS_SVH

// register indices; byte address is four times the index
`define MM_IDX_RAM_POS 6'h10
`define MM_IDX_REG_POS 6'h11
`define MM_IDX_EE_POS 6'h12
`define MM_IDX_MISC 6'h13

// position registers: five-bit base in bits 7..3, eeprom base in 7..4
`define MM_BASE5_HI 7
`define MM_BASE5_LO 3
`define MM_EE_BASE_HI 7
`define MM_EE_BASE_LO 4
`define MM_EE_ENABLE 0

// misc mapping control fields
`define MM_FLASH_SWAP 7
`define MM_NARROW_FOLLOW 6
`define MM_FOLLOW_STR_HI 5
`define MM_FOLLOW_STR_LO 4
`define MM_EXT_STR_HI 3
`define MM_EXT_STR_LO 2
`define MM_SMALL_FLASH_EN 1
`define MM_LARGE_FLASH_EN 0

// reset values
`define MM_RAM_POS_RST 8'h00
`define MM_REG_POS_RST 8'h00
`define MM_EE_POS_RST 8'h01
`define MM_MISC_RST 8'h0c
`define MM_FLASH_EN_SC 2'b11

// window details inside the aligned blocks
`define MM_REG_SUB 2'b00
`define MM_FOLLOW_SUB 2'b01
`define MM_EE_SUB 2'b11
`define MM_FLASH_HOLE 3'h0
`define MM_DEBUG_PAGE 8'hff

`endif

// ### rtl/memory_map_pkg.sv
// types shared by the address-map decoder files
package memory_map_pkg;
   // resource claimed by one access
   typedef enum logic [3:0] {
      res_none,
      res_debug_rom,
      res_registers,
      res_ram,
      res_eeprom,
      res_small_flash,
      res_large_flash,
      res_following,
      res_external
   } resource_t;
endpackage

// ### rtl/map_resolve.sv
// combinational priority decode of one address against the current map
`timescale 1ns/10ps
`default_nettype none
`include "memory_map_defs.svh"

module map_resolve
(
   input wire logic [15:0] addr,
   input wire logic [7:0] ram_pos,
   input wire logic [7:0] reg_pos,
   input wire logic [7:0] ee_pos,
   input wire logic [7:0] misc,
   input wire logic mode_expanded,
   input wire logic mode_wide,
   input wire logic debug_rom_active,
   output memory_map_pkg::resource_t resource,
   output logic bus_wide,
   output logic [1:0] stretch
);
   import memory_map_pkg::*;

   logic in_reg_win;
   logic hit_reg;
   logic hit_follow;
   logic hit_ram;
   logic hit_ee;
   logic hit_small;
   logic hit_large;
   logic swap;

   // window matches
   always_comb
   begin
      swap = misc[`MM_FLASH_SWAP];
      in_reg_win = addr[15:11] == reg_pos[`MM_BASE5_HI:`MM_BASE5_LO];
      hit_reg = in_reg_win && addr[10:9] == `MM_REG_SUB;
      hit_follow = in_reg_win && addr[10:9] == `MM_FOLLOW_SUB;
      hit_ram = addr[15:11] == ram_pos[`MM_BASE5_HI:`MM_BASE5_LO];
      hit_ee = ee_pos[`MM_EE_ENABLE]
         && addr[15:12] == ee_pos[`MM_EE_BASE_HI:`MM_EE_BASE_LO]
         && addr[11:10] == `MM_EE_SUB;
      // small array fills its half except the lowest 4K
      hit_small = misc[`MM_SMALL_FLASH_EN] && addr[15] == swap
         && addr[14:12] != `MM_FLASH_HOLE;
      hit_large = misc[`MM_LARGE_FLASH_EN] && addr[15] == !swap;
   end

   // priority: debug rom, registers, ram, eeprom, flash, external
   always_comb
   begin
      resource = res_none;
      bus_wide = 1'b1;
      stretch = 2'b00;
      if (debug_rom_active && addr[15:8] == `MM_DEBUG_PAGE)
         resource = res_debug_rom;
      else if (hit_reg)
         resource = res_registers;
      else if (hit_ram)
         resource = res_ram;
      else if (hit_ee)
         resource = res_eeprom;
      else if (hit_small)
         resource = res_small_flash;
      else if (hit_large)
         resource = res_large_flash;
      else if (mode_expanded)
      begin
         // narrow modes never widen; stretch only exists off chip
         if (hit_follow)
         begin
            resource = res_following;
            bus_wide = mode_wide && !misc[`MM_NARROW_FOLLOW];
            stretch = misc[`MM_FOLLOW_STR_HI:`MM_FOLLOW_STR_LO];
         end
         else
         begin
            resource = res_external;
            bus_wide = mode_wide;
            stretch = misc[`MM_EXT_STR_HI:`MM_EXT_STR_LO];
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/ext_bus_model.sv
// behavioural off-chip bus partner: counts external cycles and their stretch
`timescale 1ns/10ps
`default_nettype none
module ext_bus_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic dec_valid,
   input wire memory_map_pkg::resource_t dec_resource,
   input wire logic [1:0] dec_stretch,
   output logic [7:0] ext_count,
   output logic [1:0] wait_left
);
   import memory_map_pkg::*;
   // a later access overwrites the remaining stretch; fine for counting only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_count <= 8'h00;
         wait_left <= 2'h0;
      end
      else if (dec_valid && (dec_resource == res_external || dec_resource == res_following))
      begin
         ext_count <= ext_count + 8'h01;
         wait_left <= dec_stretch;
      end
      else if (wait_left != 2'h0)
         wait_left <= wait_left - 2'h1;
   end
endmodule
`default_nettype wire

// ### sim/test_memory_map_decoder.sv
// self-checking bench for the address-map decoder
`timescale 1ns/10ps
`default_nettype none
`include "memory_map_defs.svh"
module test_memory_map_decoder;
   import memory_map_pkg::*;
   localparam logic [7:0] A_RAM = {`MM_IDX_RAM_POS, 2'b00};
   localparam logic [7:0] A_REG = {`MM_IDX_REG_POS, 2'b00};
   localparam logic [7:0] A_EE = {`MM_IDX_EE_POS, 2'b00};
   localparam logic [7:0] A_MISC = {`MM_IDX_MISC, 2'b00};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic mode_special = 1'b1;
   logic mode_expanded = 1'b1;
   logic mode_wide = 1'b1;
   logic debug_rom_active = 1'b0;
   logic acc_valid = 1'b0;
   logic [15:0] acc_addr = 16'h0;
   logic acc_16bit = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic dec_valid;
   resource_t dec_resource;
   logic dec_bus_wide;
   logic [1:0] dec_stretch;
   logic dec_addr0;
   logic low_byte_strobe_n;
   logic [7:0] ext_count;
   logic [15:0] lfsr = 16'h000d;
   logic [33:0] apb_q[$];
   logic [33:0] dec_q[$];
   logic [33:0] e;
   int err_total = 0;
   int cmp_count = 0;

   memory_map_decoder #(.ADDR_W(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_special(mode_special),
      .mode_expanded(mode_expanded), .mode_wide(mode_wide),
      .debug_rom_active(debug_rom_active), .acc_valid(acc_valid), .acc_addr(acc_addr),
      .acc_16bit(acc_16bit), .dec_valid(dec_valid), .dec_resource(dec_resource),
      .dec_bus_wide(dec_bus_wide), .dec_stretch(dec_stretch), .dec_addr0(dec_addr0),
      .low_byte_strobe_n(low_byte_strobe_n));

   ext_bus_model partner (.pclk(pclk), .presetn(presetn), .dec_valid(dec_valid),
      .dec_resource(dec_resource), .dec_stretch(dec_stretch), .ext_count(ext_count),
      .wait_left());

   // 40 MHz bus clock
   always #12.5 pclk = ~pclk;

   function automatic logic [15:0] next_lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic check(input string what, input logic [33:0] x, input logic [33:0] g);
      cmp_count++;
      if (g !== x)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, x, g);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // mode pins only change while reset is held
   task automatic do_reset(input logic sp, input logic ex, input logic wd);
      presetn <= 1'b0;
      mode_special <= sp;
      mode_expanded <= ex;
      mode_wide <= wd;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] st, input logic er, input logic [7:0] x);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= st;
      apb_q.push_back({~w, er, 24'h0, x});
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         err_total++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 4'hf, 1'b0, 8'h00);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      apb(1'b0, a, 8'h00, 4'h0, 1'b0, x);
   endtask

   // one access per cycle; expected strobe from size, a0 and ram hit
   task automatic acc(input logic [15:0] a, input logic w, input resource_t r,
      input logic wd, input logic [1:0] s);
      @(posedge pclk);
      acc_valid <= 1'b1;
      acc_addr <= a;
      acc_16bit <= w;
      dec_q.push_back({25'h0, r, wd, s, a[0], w ? (a[0] & (r == res_ram)) : ~a[0]});
   endtask

   task automatic idle();
      @(posedge pclk);
      acc_valid <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   // monitor: oldest note against each result as it appears
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1)
      begin
         e = apb_q.pop_front();
         check("apb", e[32:0], {1'b0, pslverr, e[33] ? prdata : e[31:0]});
      end
      if (dec_valid === 1'b1)
         check("decode", dec_q.pop_front(), {25'h0, dec_resource, dec_bus_wide,
            dec_stretch, dec_addr0, low_byte_strobe_n});
   end

   // watchdog, far beyond the fewer than two hundred cycles the run needs
   initial
   begin
      repeat (20000) @(posedge pclk);
      err_total++;
      give_verdict();
   end

   initial
   begin
      do_reset(1'b1, 1'b1, 1'b1);
      rd(A_RAM, 8'h00);
      rd(A_REG, 8'h00);
      rd(A_EE, 8'h01);
      rd(A_MISC, 8'h0c);
      apb(1'b0, 8'h50, 8'h00, 4'h0, 1'b1, 8'h00);
      apb(1'b1, 8'h50, 8'hff, 4'hf, 1'b1, 8'h00);
      acc(16'h0000, 1'b1, res_registers, 1'b1, 2'h0);
      acc(16'h01ff, 1'b0, res_registers, 1'b1, 2'h0);
      acc(16'h0200, 1'b0, res_ram, 1'b1, 2'h0);
      acc(16'h0c00, 1'b1, res_eeprom, 1'b1, 2'h0);
      acc(16'h1000, 1'b1, res_external, 1'b1, 2'h3);
      idle();
      wr(A_RAM, 8'hff);
      rd(A_RAM, 8'hf8);
      wr(A_MISC, 8'he6);
      wr(A_REG, 8'h08);
      wr(A_RAM, 8'h10);
      rd(A_RAM, 8'h10);
      wr(A_EE, 8'h20);
      acc(16'h0800, 1'b1, res_registers, 1'b1, 2'h0);
      acc(16'h0a01, 1'b1, res_following, 1'b0, 2'h2);
      acc(16'h1001, 1'b1, res_ram, 1'b1, 2'h0);
      idle();
      wr(A_MISC, 8'he7);
      acc(16'h2c00, 1'b0, res_large_flash, 1'b1, 2'h0);
      acc(16'h9000, 1'b1, res_small_flash, 1'b1, 2'h0);
      acc(16'h8000, 1'b1, res_external, 1'b1, 2'h1);
      debug_rom_active <= 1'b1;
      acc(16'hffff, 1'b0, res_debug_rom, 1'b1, 2'h0);
      idle();
      debug_rom_active <= 1'b0;
      wr(A_EE, 8'h21);
      for (int i = 0; i < 8; i++)
      begin
         lfsr = next_lfsr(lfsr);
         acc({5'h02, lfsr[10:0]}, lfsr[11], res_ram, 1'b1, 2'h0);
      end
      acc(16'h2c00, 1'b0, res_eeprom, 1'b1, 2'h0);
      idle();
      check("ext count", 34'h3, {26'h0, ext_count});
      do_reset(1'b0, 1'b1, 1'b0);
      apb(1'b1, A_RAM, 8'h08, 4'h0, 1'b0, 8'h00);
      rd(A_RAM, 8'h00);
      wr(A_RAM, 8'h08);
      wr(A_RAM, 8'h10);
      rd(A_RAM, 8'h08);
      wr(A_MISC, 8'h5c);
      acc(16'h0200, 1'b0, res_following, 1'b0, 2'h1);
      acc(16'h4000, 1'b1, res_external, 1'b0, 2'h3);
      idle();
      do_reset(1'b0, 1'b0, 1'b1);
      rd(A_MISC, 8'h0f);
      acc(16'h1000, 1'b1, res_small_flash, 1'b1, 2'h0);
      acc(16'h8000, 1'b1, res_large_flash, 1'b1, 2'h0);
      acc(16'h0a00, 1'b1, res_none, 1'b1, 2'h0);
      idle();
      wr(A_MISC, 8'h0d);
      acc(16'h1000, 1'b1, res_none, 1'b1, 2'h0);
      idle();
      give_verdict();
   end
endmodule
`default_nettype wire
